// *** fdm_cfg.svh ***
// constants for the flash-disk mode/config register bank
// assumes byte offsets within the 8KB device window, 13-bit address
`ifndef FDM_CFG_SVH
`define FDM_CFG_SVH
`define FDM_AW              13
`define FDM_OFF_CASCADE_SEL 13'h100a
`define FDM_OFF_MODE_CTRL   13'h100c
`define FDM_OFF_CONFIG      13'h100e
`define FDM_OFF_CONFIRM     13'h1072
`define FDM_OFF_SWAP_CTRL   13'h1008
`define FDM_BOOT_LO_END     13'h0800
`define FDM_BOOT_HI_START   13'h1800
`define FDM_BIT_LOW_SWAP    0
`define FDM_BIT_HIGH_SWAP   8
`define FDM_BIT_UNLOCK      2
`define FDM_BIT_BOOT_FLAG   3
`define FDM_BIT_HRST_FLAG   4
`define FDM_BIT_IO_SUPPLY   0
`define FDM_BIT_STRAP       7
`define FDM_MODE_RESET      2'b00
`define FDM_MODE_NORMAL     2'b01
`define FDM_MODE_DPD        2'b10
// host controller register offsets on axi4-lite
`define FDM_H_CMD           4'h0
`define FDM_H_WDATA         4'h4
`define FDM_H_STATUS        4'h8
`define FDM_H_RDATA         4'hc
`endif

// *** fdm_pkg.sv ***
// types shared by both ends of the mode/config register link
// assumes fdm_cfg.svh constants
`include "fdm_cfg.svh"
package fdm_pkg;
  typedef logic [`FDM_AW-1:0] fdm_addr_t;
  typedef logic [15:0]        fdm_data_t;
  typedef logic [1:0]         fdm_mode_t;
  typedef enum logic [1:0] {
    FDM_H_IDLE = 2'b00,
    FDM_H_REQ  = 2'b01,
    FDM_H_DONE = 2'b11
  } fdm_hstate_t;
endpackage : fdm_pkg

// *** fdm_link_if.sv ***
// memory-mapped register link between host controller and device
// assumes one shared clock; a request completes in the cycle it is strobed
`timescale 1ns/10ps
interface fdm_link_if;
  import fdm_pkg::*;
  logic      req;
  logic      wr;
  logic      wide;
  fdm_addr_t addr;
  fdm_data_t wdata;
  fdm_data_t rdata;
  modport dev  (input req, wr, wide, addr, wdata, output rdata);
  modport host (output req, wr, wide, addr, wdata, input rdata);
endinterface : fdm_link_if

// *** fdm_host.sv ***
// host-side controller: axi4-lite slave that issues single link accesses
// assumes link answers reads combinationally in the request cycle
`timescale 1ns/10ps
`include "fdm_cfg.svh"
module fdm_host (
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset_n,
  input  wire logic [3:0]   i_awaddr,
  input  wire logic         i_awvalid,
  output logic              o_awready,
  input  wire logic [31:0]  i_wdata,
  input  wire logic [3:0]   i_wstrb,
  input  wire logic         i_wvalid,
  output logic              o_wready,
  output logic [1:0]        o_bresp,
  output logic              o_bvalid,
  input  wire logic         i_bready,
  input  wire logic [3:0]   i_araddr,
  input  wire logic         i_arvalid,
  output logic              o_arready,
  output logic [31:0]       o_rdata,
  output logic [1:0]        o_rresp,
  output logic              o_rvalid,
  input  wire logic         i_rready,
  fdm_link_if.host          link
);
  import fdm_pkg::*;
  // cmd: [12:0] addr, [16] write, [17] wide, [31] go
  logic [31:0] cmd_r;
  logic [15:0] wd_r;
  logic [15:0] rd_r;
  logic        busy_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [3:0]  aw_r;
  logic [31:0] w_r;
  logic        do_wr;
  assign o_awready = !aw_got_r && !o_bvalid;
  assign o_wready  = !w_got_r && !o_bvalid;
  assign do_wr     = (aw_got_r || (i_awvalid && o_awready))
                  && (w_got_r || (i_wvalid && o_wready));
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      aw_r     <= 4'h0;
      w_r      <= 32'h0;
      o_bvalid <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_r <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_r <= i_wdata;
      end
      aw_got_r <= do_wr ? 1'b0 : (aw_got_r || (i_awvalid && o_awready));
      w_got_r  <= do_wr ? 1'b0 : (w_got_r || (i_wvalid && o_wready));
      if (do_wr) begin
        o_bvalid <= 1'b1;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end
  assign o_bresp = 2'b00;
  logic [3:0]  wa;
  logic [31:0] wv;
  assign wa = aw_got_r ? aw_r : i_awaddr;
  assign wv = w_got_r ? w_r : i_wdata;
  // one link access per go; the issuing cycle clears go
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      cmd_r  <= 32'h0;
      wd_r   <= 16'h0;
      rd_r   <= 16'h0;
      busy_r <= 1'b0;
    end else begin
      if (busy_r) begin
        busy_r <= 1'b0;
        if (!cmd_r[16]) begin
          rd_r <= link.rdata;
        end
      end
      if (do_wr && wa == `FDM_H_CMD && !busy_r) begin
        cmd_r  <= wv;
        busy_r <= wv[31];
      end else if (busy_r) begin
        cmd_r[31] <= 1'b0;
      end
      if (do_wr && wa == `FDM_H_WDATA) begin
        wd_r <= wv[15:0];
      end
    end
  end
  assign link.req   = busy_r;
  assign link.wr    = cmd_r[16];
  assign link.wide  = cmd_r[17];
  assign link.addr  = cmd_r[12:0];
  assign link.wdata = wd_r;
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      unique case (i_araddr)
        `FDM_H_CMD:    o_rdata <= cmd_r;
        `FDM_H_WDATA:  o_rdata <= {16'h0, wd_r};
        `FDM_H_STATUS: o_rdata <= {31'h0, busy_r};
        `FDM_H_RDATA:  o_rdata <= {16'h0, rd_r};
        default:       o_rdata <= 32'h0;
      endcase
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end
  assign o_arready = !o_rvalid;
  assign o_rresp   = 2'b00;
endmodule : fdm_host

// *** fdm_dev.sv ***
// device end: mode control, confirm, reset-cause flags, cascade select,
// configuration straps and byte-lane swap.
// assumes link requests last one cycle; reads answered combinationally.
// Operation
// - swap bytes on 16-bit access when enabled
// - swap enables at bits 0 and 8
// - 8-bit-only hosts may skip swap register
// - host writes complement to confirm register
// - no other access between, except boot
// - confirm write-only; control reads stored value
// - mode bits: reset, normal, deep power-down
// - mode changes only with unlock bit set
// - unlock bit always reads zero
// - boot trigger flag, write one clears
// - hard reset cause flag, write one clears
// - respond only when index pins match select
// - configuration cleared only by hardware reset
// - bit 0 reports io supply level
// - highest cascade index at bits 5-4
// - bit 7 mirrors interface strap pin
// - all registers read zero in reset mode
// - reserved zero bits read zero
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "fdm_cfg.svh"
module fdm_dev (
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_reset_input_n,
  input  wire logic         i_voltage_trip,
  input  wire logic         i_boot_trigger,
  input  wire logic [1:0]   i_cascade_index,
  input  wire logic         i_io_supply_high,
  input  wire logic         i_if_strap,
  output fdm_pkg::fdm_mode_t o_mode,
  output logic              o_swap_active,
  fdm_link_if.dev           link
);
  import fdm_pkg::*;
  fdm_mode_t  mode_r;
  logic       boot_trigger_flag_r;
  logic       hard_reset_cause_flag_r;
  logic [1:0] cascade_sel_r;
  logic [1:0] highest_cascade_index_r;
  logic       low_lane_swap_en_r;
  logic       high_lane_swap_en_r;
  logic       pend_r;
  logic [7:0] pend_val_r;
  logic       selected;
  logic       in_reset;
  logic       boot_acc;
  logic       wr_hit;
  logic [7:0] wb;
  logic       confirm_ok;
  logic       hw_reset_evt;
  function automatic logic is_boot(input fdm_addr_t a);
    is_boot = (a < `FDM_BOOT_LO_END) || (a >= `FDM_BOOT_HI_START);
  endfunction : is_boot
  assign in_reset     = (mode_r == `FDM_MODE_RESET);
  assign selected     = (i_cascade_index == cascade_sel_r);
  assign boot_acc     = is_boot(link.addr);
  assign wr_hit       = link.req && link.wr && selected;
  assign o_swap_active = low_lane_swap_en_r && high_lane_swap_en_r;
  assign wb = (link.wide && o_swap_active) ? link.wdata[15:8] : link.wdata[7:0];
  assign confirm_ok = pend_r && wr_hit && link.addr == `FDM_OFF_CONFIRM
                   && wb == ~pend_val_r;
  assign hw_reset_evt = !i_reset_input_n || i_voltage_trip;
  assign o_mode = mode_r;
  // pending control write; any non-boot access to this device while selected in between drops it
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      pend_r     <= 1'b0;
      pend_val_r <= 8'h00;
    end else if (link.req && selected && !boot_acc) begin
      pend_r     <= wr_hit && link.addr == `FDM_OFF_MODE_CTRL;
      pend_val_r <= wb;
    end
  end
  // mode: forced to reset by the pin, voltage trip or boot detector
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      mode_r <= `FDM_MODE_RESET;
    end else if (hw_reset_evt || i_boot_trigger) begin
      mode_r <= `FDM_MODE_RESET;
    end else if (confirm_ok && pend_val_r[`FDM_BIT_UNLOCK]
                 && pend_val_r[1:0] != 2'b11) begin
      mode_r <= pend_val_r[1:0];
    end
  end
  // sticky cause flags; set wins over a same-cycle clear
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      boot_trigger_flag_r     <= 1'b0;
      hard_reset_cause_flag_r <= 1'b1;
    end else begin
      if (i_boot_trigger) begin
        boot_trigger_flag_r <= 1'b1;
      end else if (confirm_ok && pend_val_r[`FDM_BIT_BOOT_FLAG]) begin
        boot_trigger_flag_r <= 1'b0;
      end
      if (hw_reset_evt) begin
        hard_reset_cause_flag_r <= 1'b1;
      end else if (confirm_ok && pend_val_r[`FDM_BIT_HRST_FLAG]) begin
        hard_reset_cause_flag_r <= 1'b0;
      end
    end
  end
  // cascade select and swap go back to defaults while in reset mode
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || in_reset) begin
      cascade_sel_r       <= 2'b00;
      low_lane_swap_en_r  <= 1'b0;
      high_lane_swap_en_r <= 1'b0;
    end else if (wr_hit) begin
      if (link.addr == `FDM_OFF_CASCADE_SEL) begin
        cascade_sel_r <= wb[1:0];
      end
      if (link.addr == `FDM_OFF_SWAP_CTRL) begin
        low_lane_swap_en_r  <= link.wdata[`FDM_BIT_LOW_SWAP];
        high_lane_swap_en_r <= link.wdata[`FDM_BIT_HIGH_SWAP];
      end
    end
  end
  // only the hardware reset clears this field
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      highest_cascade_index_r <= 2'b00;
    end else if (wr_hit && !in_reset && link.addr == `FDM_OFF_CONFIG) begin
      highest_cascade_index_r <= wb[5:4];
    end
  end
  logic [15:0] rd;
  always_comb begin
    rd = 16'h0000;
    if (selected && !in_reset) begin
      unique case (link.addr)
        `FDM_OFF_CASCADE_SEL: rd = {14'h0, cascade_sel_r};
        // unlock bit position left zero
        `FDM_OFF_MODE_CTRL: rd = {11'h0, hard_reset_cause_flag_r,
                                  boot_trigger_flag_r, 1'b0, mode_r};
        `FDM_OFF_CONFIG: rd = {8'h0, i_if_strap, 1'b0, highest_cascade_index_r,
                               3'b000, i_io_supply_high};
        `FDM_OFF_SWAP_CTRL: rd = {7'h0, high_lane_swap_en_r,
                                  7'h0, low_lane_swap_en_r};
        default: rd = 16'h0000;
      endcase
    end
  end
  assign link.rdata = (link.wide && o_swap_active) ? {rd[7:0], rd[15:8]} : rd;
endmodule : fdm_dev

// *** fdm_link_sva.sv ***
// checker on the register link between host controller and device
// assumes configuration is only read while this device is selected
`timescale 1ns/10ps
`include "fdm_cfg.svh"
module fdm_link_sva (
  input wire logic               i_ref_clk,
  input wire logic               i_reset_n,
  input wire logic               req,
  input wire logic               wr,
  input wire logic               wide,
  input wire fdm_pkg::fdm_addr_t addr,
  input wire fdm_pkg::fdm_data_t rdata,
  input wire fdm_pkg::fdm_mode_t o_mode,
  input wire logic               i_boot_trigger,
  input wire logic               i_reset_input_n,
  input wire logic               i_voltage_trip,
  input wire logic               i_if_strap,
  input wire logic               i_io_supply_high
);
  import fdm_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  wire rd = req && !wr && !wide;
  wire cause = i_boot_trigger || !i_reset_input_n || i_voltage_trip;
  req_pulse_a: assert property (req |=> !req)
    else $error("link request held longer than one cycle");
  legal_mode_a: assert property (o_mode != 2'b11)
    else $error("undefined mode stored");
  reset_reads_a: assert property (req && !wr && o_mode == `FDM_MODE_RESET |-> rdata == 16'h0)
    else $error("nonzero read in reset mode");
  unlock_zero_a: assert property (rd && addr == `FDM_OFF_MODE_CTRL |->
    rdata[`FDM_BIT_UNLOCK] == 1'b0 && rdata[7:5] == 3'b000) else $error("unlock bit read back");
  strap_read_a: assert property (rd && addr == `FDM_OFF_CONFIG && o_mode == `FDM_MODE_NORMAL |->
    rdata[7] == i_if_strap && rdata[0] == i_io_supply_high && rdata[6] == 1'b0
    && rdata[3:1] == 3'b000) else $error("configuration pins misreported");
  boot_entry_a: assert property (i_boot_trigger |=> o_mode == `FDM_MODE_RESET)
    else $error("boot trigger did not force reset mode");
  pin_entry_a: assert property (!i_reset_input_n || i_voltage_trip |=> !o_mode)
    else $error("reset pin or voltage trip did not force reset mode");
  mode_cause_a: assert property (o_mode != $past(o_mode) && !$past(cause) |->
    $past(req && wr && addr == `FDM_OFF_CONFIRM)) else $error("mode changed without confirm");
  cover property (req && wr && addr == `FDM_OFF_CONFIRM);
  cover property (o_mode == `FDM_MODE_DPD);
  cover property (rd && addr == `FDM_OFF_CONFIG && o_mode == `FDM_MODE_NORMAL);
endmodule : fdm_link_sva

// *** flash_disk_mode_config_regs_tb.sv ***
// bench driving the host controller over axi4-lite against the device end
// starts at cascade index 0 so the device owns the register space, except while the cascade-select test moves the select and pins
`timescale 1ns/10ps
`include "fdm_cfg.svh"
module flash_disk_mode_config_regs_tb;
  import fdm_pkg::*;
  logic        clk, rst_n, rin_n, vtrip, boot, ioh, strap, awvalid, wvalid, bready, arvalid;
  logic        rready;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [1:0]  id, cidx;
  fdm_data_t   r;
  wire         awready, wready, bvalid, arready, rvalid, swp;
  wire [31:0]  rdata;
  fdm_mode_t   mode;
  int          mismatches, n_tests, cyc, seed;
  fdm_link_if u_fdm_link_if();
  fdm_host u_fdm_host(.i_ref_clk(clk), .i_reset_n(rst_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(), .o_rvalid(rvalid), .i_rready(rready), .link(u_fdm_link_if));
  fdm_dev u_fdm_dev(.i_ref_clk(clk), .i_reset_n(rst_n), .i_reset_input_n(rin_n),
    .i_voltage_trip(vtrip), .i_boot_trigger(boot), .i_cascade_index(cidx),
    .i_io_supply_high(ioh), .i_if_strap(strap), .o_mode(mode), .o_swap_active(swp),
    .link(u_fdm_link_if));
  fdm_link_sva u_fdm_link_sva(.i_ref_clk(clk), .i_reset_n(rst_n), .req(u_fdm_link_if.req),
    .wr(u_fdm_link_if.wr), .wide(u_fdm_link_if.wide), .addr(u_fdm_link_if.addr),
    .rdata(u_fdm_link_if.rdata), .o_mode(mode), .i_boot_trigger(boot),
    .i_reset_input_n(rin_n), .i_voltage_trip(vtrip), .i_if_strap(strap),
    .i_io_supply_high(ioh));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic finish_test();
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  function automatic logic [7:0] cfg(input logic s, input logic io, input logic [1:0] i);
    return {s, 1'b0, i, 3'b000, io};
  endfunction : cfg
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    bit ad, wd, bd;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bd) begin
      @(posedge clk);
      bd = ad && wd && bvalid;
      if (!ad && awready) awvalid <= 1'b0;
      if (!wd && wready) wvalid <= 1'b0;
      ad = ad || awready;
      wd = wd || wready;
    end
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    bit ad, dn;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!dn) begin
      @(posedge clk);
      dn = ad && rvalid;
      d = rdata;
      if (!ad && arready) arvalid <= 1'b0;
      ad = ad || arready;
    end
    rready <= 1'b0;
  endtask : axr
  // one link access: command, poll busy, then fetch the captured read data
  task automatic lk(input logic w, input logic wd, input fdm_addr_t a, input fdm_data_t d);
    logic [31:0] s;
    int          n;
    axw(`FDM_H_WDATA, {16'h0, d});
    axw(`FDM_H_CMD, {1'b1, 13'h0, wd, w, 3'h0, a});
    do begin
      axr(`FDM_H_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 50);
    axr(`FDM_H_RDATA, s);
    r = s[15:0];
  endtask : lk
  task automatic mc(input logic [7:0] b);
    lk(1'b1, 1'b0, `FDM_OFF_MODE_CTRL, {8'h0, b});
    lk(1'b1, 1'b0, `FDM_OFF_CONFIRM, {8'h0, ~b});
  endtask : mc
  task automatic rst();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
  endtask : rst
  initial begin
    {rst_n, vtrip, boot, ioh, strap, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, id, cidx} = '0;
    rin_n = 1'b1;
    seed = 32'h159956db;
    rst();
    lk(1'b0, 1'b0, `FDM_OFF_MODE_CTRL, 16'h0);
    chk(r[7:0], 8'h00);
    mc(8'h05);
    chk(mode, `FDM_MODE_NORMAL);
    lk(1'b0, 1'b0, `FDM_OFF_MODE_CTRL, 16'h0);
    chk(r[7:0], 8'h11);
    mc(8'h01);
    lk(1'b0, 1'b0, `FDM_OFF_MODE_CTRL, 16'h0);
    chk(r[7:0], 8'h11);
    lk(1'b1, 1'b0, `FDM_OFF_MODE_CTRL, 16'h6);
    lk(1'b1, 1'b0, `FDM_OFF_CONFIRM, 16'h0);
    lk(1'b1, 1'b0, `FDM_OFF_MODE_CTRL, 16'h6);
    lk(1'b0, 1'b0, `FDM_OFF_CONFIG, 16'h0);
    lk(1'b1, 1'b0, `FDM_OFF_CONFIRM, 16'hf9);
    mc(8'h02);
    mc(8'h07);
    chk(mode, `FDM_MODE_NORMAL);
    lk(1'b1, 1'b0, `FDM_OFF_MODE_CTRL, 16'h6);
    lk(1'b0, 1'b0, 13'h0010, 16'h0);
    lk(1'b1, 1'b0, `FDM_OFF_CONFIRM, 16'hf9);
    chk(mode, `FDM_MODE_DPD);
    mc(8'h15);
    chk(mode, `FDM_MODE_NORMAL);
    for (int i = 0; i < 6; i++) begin
      {strap, ioh} <= 2'($random(seed));
      id = 2'($random(seed));
      lk(1'b1, 1'b0, `FDM_OFF_CONFIG, {10'h0, id, 4'h0});
      lk(1'b0, 1'b0, `FDM_OFF_CONFIG, 16'h0);
      chk(r[7:0], cfg(strap, ioh, id));
    end
    // move the select away: this device must go quiet until the pins follow
    lk(1'b1, 1'b0, `FDM_OFF_CASCADE_SEL, 16'h0001);
    lk(1'b0, 1'b0, `FDM_OFF_MODE_CTRL, 16'h0);
    chk(r[7:0], 8'h00);
    lk(1'b1, 1'b0, `FDM_OFF_CONFIG, 16'h0000);
    cidx <= 2'b01;
    lk(1'b0, 1'b0, `FDM_OFF_MODE_CTRL, 16'h0);
    chk(r[7:0], 8'h01);
    lk(1'b0, 1'b0, `FDM_OFF_CONFIG, 16'h0);
    chk(r[7:0], cfg(strap, ioh, id));
    lk(1'b1, 1'b0, `FDM_OFF_CASCADE_SEL, 16'h0000);
    cidx <= 2'b00;
    lk(1'b0, 1'b0, `FDM_OFF_CASCADE_SEL, 16'h0);
    chk(r, 16'h0000);
    lk(1'b1, 1'b1, `FDM_OFF_SWAP_CTRL, 16'h0001);
    lk(1'b0, 1'b1, `FDM_OFF_CONFIG, 16'h0);
    chk(r, {8'h0, cfg(strap, ioh, id)});
    lk(1'b1, 1'b1, `FDM_OFF_SWAP_CTRL, 16'h0101);
    lk(1'b1, 1'b1, `FDM_OFF_CONFIG, 16'h3000);
    lk(1'b0, 1'b1, `FDM_OFF_CONFIG, 16'h0);
    chk(r, {cfg(strap, ioh, 2'b11), 8'h0});
    lk(1'b0, 1'b0, `FDM_OFF_CONFIG, 16'h0);
    chk(r, {8'h0, cfg(strap, ioh, 2'b11)});
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      boot <= (k == 0);
      rin_n <= (k != 1);
      vtrip <= (k == 2);
      @(posedge clk);
      {boot, vtrip, rin_n} <= 3'b001;
      lk(1'b0, 1'b0, `FDM_OFF_CONFIG, 16'h0);
      chk(r[7:0], 8'h00);
      mc(8'h05);
      lk(1'b0, 1'b0, `FDM_OFF_MODE_CTRL, 16'h0);
      chk(r[7:0], k == 0 ? 8'h09 : 8'h11);
      mc(r[7:0]);
      lk(1'b0, 1'b0, `FDM_OFF_MODE_CTRL, 16'h0);
      chk(r[7:0], 8'h01);
      lk(1'b0, 1'b0, `FDM_OFF_CONFIG, 16'h0);
      chk(r[7:0], cfg(strap, ioh, 2'b11));
    end
    lk(1'b0, 1'b1, `FDM_OFF_SWAP_CTRL, 16'h0);
    chk(r, 16'h0000);
    chk({15'h0, swp}, 16'h0000);
    rst();
    mc(8'h05);
    lk(1'b0, 1'b0, `FDM_OFF_CONFIG, 16'h0);
    chk(r[7:0], cfg(strap, ioh, 2'b00));
    finish_test();
  end
endmodule : flash_disk_mode_config_regs_tb
